// ===== verilog/gys_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The port is a serial slave in mode zero only, clock idling low.
// - The data-out pin is released whenever select is high.
// - The port works only while the active-high enable input is high.
// - A low calibration reset pin asks the core to reload calibration.
// - The self-test output is one while the sensor is fine and enable is high, low on a fault or in power down.
// - The port reacts to serial traffic only while select is low.
// - A frame is one instruction byte then 2, 4 or 8 argument bytes.
// - The ready flag in the rate word rises on a new sample and stays until read.
// - Enable low puts the device in power down.
module gys_spi_port #(
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic ssel_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    input wire logic enable,
    input wire logic calibration_reload_reset_n,
    input wire logic drive_ok,
    input wire gys_pkg::gys_sample_s sample,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic self_test_ok,
    output logic calib_reload,
    output logic power_down,
    output logic [7:0] instr,
    output logic instr_valid
);
    // Two-flop synchronisers for all pins
    logic [1:0] s_sclk, s_ssel, s_mosi, s_en, s_rst;
    logic sclk_d;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_sclk <= 2'h0;
            s_ssel <= 2'h3;
            s_mosi <= 2'h0;
            s_en <= 2'h0;
            s_rst <= 2'h3;
            sclk_d <= 1'b0;
        end else begin
            s_sclk <= {s_sclk[0], sclk};
            s_ssel <= {s_ssel[0], ssel_n};
            s_mosi <= {s_mosi[0], mosi};
            s_en <= {s_en[0], enable};
            s_rst <= {s_rst[0], calibration_reload_reset_n};
            sclk_d <= s_sclk[1];
        end
    end
    logic sel, rise, fall, en;
    assign en = s_en[1];
    assign sel = ~s_ssel[1] & en;
    assign rise = s_sclk[1] & ~sclk_d;
    assign fall = ~s_sclk[1] & sclk_d;
    assign power_down = ~en;
    assign calib_reload = ~s_rst[1];
    assign self_test_ok = drive_ok & en;

    // Two-entry sample buffer; the core stalls when both slots hold unread samples
    gys_pkg::gys_sample_s buf_q [DEPTH];
    logic [1:0] cnt, next_cnt;
    logic rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
    logic pop;
    assign sample_ready = (cnt != 2'(DEPTH));
    always_comb begin
        next_cnt = cnt;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        if (sample_valid && sample_ready) begin
            next_wr_ptr = ~wr_ptr;
        end
        if (pop && cnt != 2'h0) begin
            next_rd_ptr = ~rd_ptr;
        end
        next_cnt = cnt + 2'(sample_valid && sample_ready) - 2'(pop && cnt != 2'h0);
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            cnt <= next_cnt;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
        end
    end
    always_ff @(posedge clock) begin
        if (sample_valid && sample_ready) begin
            buf_q[wr_ptr] <= sample;
        end
    end

    // Oldest unread sample presented; ready flag is high while an unread sample waits
    gys_pkg::gys_sample_s head;
    logic ready_flag;
    assign head = buf_q[rd_ptr];
    assign ready_flag = (cnt != 2'h0);

    function automatic logic [3:0] arg_len(input logic [7:0] c);
        case (c)
            gys_pkg::CMD_READ_TEMP, gys_pkg::CMD_ADV_C: arg_len = gys_pkg::ARG_BYTES_2;
            gys_pkg::CMD_ADV_B: arg_len = gys_pkg::ARG_BYTES_8;
            default: arg_len = gys_pkg::ARG_BYTES_4;
        endcase
    endfunction

    // Serial frame engine
    typedef enum logic [1:0] {FR_IDLE, FR_INSTR, FR_ARG} gys_state_e;
    gys_state_e state, next_state;
    logic [2:0] bitc, next_bitc;
    logic [6:0] argbits, next_argbits;
    logic [7:0] shin, next_shin;
    logic [31:0] shout, next_shout;
    logic [7:0] next_instr;
    logic next_instr_valid, next_miso;
    always_comb begin
        next_state = state;
        next_bitc = bitc;
        next_argbits = argbits;
        next_shin = shin;
        next_shout = shout;
        next_instr = instr;
        next_instr_valid = 1'b0;
        next_miso = miso_o;
        pop = 1'b0;
        if (!sel) begin
            next_state = FR_IDLE;
            next_bitc = 3'h0;
            next_miso = 1'b0;
        end else begin
            case (state)
                FR_IDLE: begin
                    next_state = FR_INSTR;
                    next_bitc = 3'h0;
                end
                FR_INSTR: begin
                    if (rise) begin
                        next_shin = {shin[6:0], s_mosi[1]};
                        next_bitc = bitc + 3'h1;
                        if (bitc == 3'h7) begin
                            next_instr = {shin[6:0], s_mosi[1]};
                            next_instr_valid = 1'b1;
                            next_argbits = 7'({arg_len(next_instr), 3'h0});
                            next_state = FR_ARG;
                            if (next_instr == gys_pkg::CMD_READ_RATE) begin
                                next_shout = {head.rate, ready_flag, self_test_ok, 6'h00};
                                pop = 1'b1;
                            end else if (next_instr == gys_pkg::CMD_READ_TEMP) begin
                                next_shout = {head.temp, 4'h0, 16'h0000};
                            end else begin
                                next_shout = gys_pkg::WORD_RESET;
                            end
                        end
                    end
                end
                FR_ARG: begin
                    if (fall && argbits != 7'h00) begin
                        next_miso = shout[31];
                        next_shout = {shout[30:0], 1'b0};
                    end
                    if (rise && argbits != 7'h00) begin
                        next_argbits = argbits - 7'h01;
                        if (argbits == 7'h01) begin
                            next_state = FR_INSTR;
                            next_bitc = 3'h0;
                        end
                    end
                end
                default: next_state = FR_IDLE;
            endcase
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= FR_IDLE;
            bitc <= 3'h0;
            argbits <= 7'h00;
            shin <= gys_pkg::BYTE_RESET;
            shout <= gys_pkg::WORD_RESET;
            instr <= gys_pkg::BYTE_RESET;
            instr_valid <= 1'b0;
            miso_o <= 1'b0;
        end else begin
            state <= next_state;
            bitc <= next_bitc;
            argbits <= next_argbits;
            shin <= next_shin;
            shout <= next_shout;
            instr <= next_instr;
            instr_valid <= next_instr_valid;
            miso_o <= next_miso;
        end
    end
    assign miso_oe = sel && state == FR_ARG;

    // Pin levels held for two clocks; the synchroniser lag means a pin is only
    // guaranteed to have reached the logic one clock after such a run
    sequence seq_desel_held;
        ssel_n ##1 ssel_n;
    endsequence
    sequence seq_off_held;
        !enable ##1 !enable;
    endsequence
    sequence seq_reload_held;
        !calibration_reload_reset_n ##1 !calibration_reload_reset_n;
    endsequence

    a_miso_released: assert property (@(posedge clock) disable iff (rst)
        seq_desel_held |=> !miso_oe) else $error("data out driven while deselected");
    a_powerdown_en: assert property (@(posedge clock) disable iff (rst)
        seq_off_held |=> power_down && !self_test_ok && !miso_oe)
        else $error("active in power down");
    a_buffer_full: assert property (@(posedge clock) disable iff (rst)
        cnt == 2'h2 && !pop |=> cnt == 2'h2) else $error("full buffer changed without read");
    a_ready_hold: assert property (@(posedge clock) disable iff (rst)
        ready_flag && !pop |=> ready_flag) else $error("ready flag lost without read");
    a_instr_len: assert property (@(posedge clock) disable iff (rst)
        instr_valid && instr == gys_pkg::CMD_READ_TEMP |-> argbits == 7'h10)
        else $error("wrong argument length");
    a_reload_pin: assert property (@(posedge clock) disable iff (rst)
        seq_reload_held |=> calib_reload) else $error("reload not requested");
    a_miso_steady: assert property (@(posedge clock) disable iff (rst)
        sel && !fall |=> $stable(miso_o)) else $error("data out moved off a falling edge");
endmodule
`default_nettype wire

// ===== verilog/gys_pkg.sv
`default_nettype none
package gys_pkg;
    // Frame layout
    localparam int INSTR_BITS = 8;
    localparam logic [7:0] CMD_READ_RATE = 8'h50;
    localparam logic [7:0] CMD_READ_TEMP = 8'h54;
    localparam logic [7:0] CMD_ADV_A = 8'h58;
    localparam logic [7:0] CMD_ADV_B = 8'h78;
    localparam logic [7:0] CMD_ADV_C = 8'h7c;
    localparam logic [3:0] ARG_BYTES_2 = 4'h2;
    localparam logic [3:0] ARG_BYTES_4 = 4'h4;
    localparam logic [3:0] ARG_BYTES_8 = 4'h8;
    // Field positions in the rate and temperature words
    localparam int RATE_LSB = 8;
    localparam int READY_BIT = 7;
    localparam int SELFTEST_BIT = 6;
    localparam int TEMP_LSB = 4;
    // Reset values
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // One sample handed from the sensor core into the port
    typedef struct packed {
        logic [23:0] rate;
        logic [11:0] temp;
    } gys_sample_s;
endpackage
`default_nettype wire

// ===== test/gys_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// Serial master in mode zero; 320 ns clock stands still between frames
module gys_spi_master (
    output logic sclk,
    output logic ssel_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        ssel_n = 1'b1;
        mosi = 1'b0;
    end
    // Shift on falls, sample on rises; 3.125 MHz keeps below the limit
    task automatic xfer(input logic [7:0] c, input int n, output logic [63:0] rx);
        logic [71:0] tx;
        tx = {c, 64'h0};
        rx = 64'h0;
        // Pins move 10 ns after a clock edge, never on it
        #10;
        ssel_n = 1'b0;
        #320;
        for (int i = 0; i < 8 * (n + 1); i++) begin
            mosi = tx[71 - i];
            #160 if (i >= 8) rx = {rx[62:0], miso};
            sclk = 1'b1;
            #160 sclk = 1'b0;
        end
        #320 ssel_n = 1'b1;
        mosi = ~mosi; // Released line must not look held
        #310;
    endtask
endmodule
`default_nettype wire

// ===== test/gys_spi_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gys_spi_port_tb;
    logic clock, rst, enable, cal_rst_n, drive_ok, sample_valid, last_miso;
    logic sclk, ssel_n, mosi, miso_o, miso_oe, sample_ready, self_test_ok;
    logic calib_reload, power_down, instr_valid;
    logic [7:0] instr;
    logic [63:0] rx;
    gys_pkg::gys_sample_s sample, s0, s1, s2;
    logic [7:0] adv [3] = '{gys_pkg::CMD_ADV_A, gys_pkg::CMD_ADV_B, gys_pkg::CMD_ADV_C};
    int nb [3] = '{4, 8, 2};
    int miscompares, n_compared, cycles, pulses, p;
    wire logic miso;
    // A released line shows the inverse of its last value, not a clean level
    assign miso = miso_oe ? miso_o : ~last_miso;
    gys_spi_master u_mst (.sclk(sclk), .ssel_n(ssel_n), .mosi(mosi), .miso(miso));
    gys_spi_port u_dut (.clock(clock), .rst(rst), .sclk(sclk), .ssel_n(ssel_n),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .enable(enable),
        .calibration_reload_reset_n(cal_rst_n), .drive_ok(drive_ok), .sample(sample),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .self_test_ok(self_test_ok), .calib_reload(calib_reload),
        .power_down(power_down), .instr(instr), .instr_valid(instr_valid));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog, pulse count and bus release check
    always @(posedge clock) begin
        cycles++;
        if (miso_oe) last_miso <= miso_o;
        if (instr_valid === 1'b1) pulses++;
        if (ssel_n && miso_oe !== 1'b0) chk(miso_oe, 0, "driven unselected");
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    function automatic logic [63:0] rword(gys_pkg::gys_sample_s s, logic r);
        return {32'h0, s.rate, r, 1'b1, 6'h00};
    endfunction
    task automatic push(input gys_pkg::gys_sample_s s);
        @(posedge clock) sample <= s;
        sample_valid <= 1'b1;
        @(posedge clock);
        while (sample_ready !== 1'b1) @(posedge clock);
        sample_valid <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] c, input int n, input logic [63:0] e,
            input logic [63:0] k);
        p = pulses;
        u_mst.xfer(c, n, rx);
        chk(rx & k, e, "reply");
        chk(instr, c, "instr");
        chk(pulses - p, 1, "instr pulse");
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask
    initial begin
        void'($urandom(32'h6139));
        rst = 1'b1;
        enable = 1'b1;
        cal_rst_n = 1'b1;
        drive_ok = 1'b1;
        sample_valid = 1'b0;
        sample = '0;
        last_miso = 1'b0;
        settle(3);
        rst <= 1'b0;
        settle(4);
        chk({self_test_ok, power_down}, 2'h2, "status");
        cal_rst_n <= 1'b0;
        settle(4);
        chk(calib_reload, 1, "reload");
        cal_rst_n <= 1'b1;
        s0 = 36'({$urandom(), $urandom()});
        s1 = 36'({$urandom(), $urandom()});
        s2 = 36'({$urandom(), $urandom()});
        push(s0);
        push(s1);
        // Third offer stays up, stalled, until a rate read frees a slot
        fork
            push(s2);
            begin
                settle(4);
                chk(sample_ready, 0, "full");
                frame(gys_pkg::CMD_READ_TEMP, 2, {48'h0, s0.temp, 4'h0}, '1);
                frame(gys_pkg::CMD_READ_RATE, 4, rword(s0, 1'b1), '1);
            end
        join
        enable <= 1'b0;
        settle(4);
        chk({self_test_ok, power_down}, 2'h1, "off");
        p = pulses;
        u_mst.xfer(gys_pkg::CMD_READ_RATE, 4, rx);
        chk(pulses - p, 0, "disabled frame");
        enable <= 1'b1;
        settle(4);
        frame(gys_pkg::CMD_READ_RATE, 4, rword(s1, 1'b1), '1);
        frame(gys_pkg::CMD_READ_RATE, 4, rword(s2, 1'b1), '1);
        // Empty buffer: only the ready and self-test bits are defined
        frame(gys_pkg::CMD_READ_RATE, 4, 64'h40, 64'hc0);
        for (int i = 0; i < 3; i++) frame(adv[i], nb[i], 64'h0, '1);
        drive_ok <= 1'b0;
        settle(4);
        chk(self_test_ok, 0, "fault");
        frame(gys_pkg::CMD_READ_RATE, 4, 64'h0, 64'hc0);
        summarize();
    end
endmodule
`default_nettype wire
